//--- include/p34_pkg.sv
// ****************************************************************
// port 3 / port 4 constants
// ****************************************************************
package p34_pkg;

  // register addresses on the special function register bus
  localparam logic [7:0] ADDR_PORT3_OUTPUT_MODE   = 8'hae;
  localparam logic [7:0] ADDR_PORT3_DATA          = 8'hb0;
  localparam logic [7:0] ADDR_PORT4_DATA          = 8'hb5;
  localparam logic [7:0] ADDR_PORT3_CROSSBAR_SKIP = 8'hd7;
  localparam logic [7:0] ADDR_PORT3_INPUT_MODE    = 8'hf4;

  // page that holds the configuration registers
  localparam logic [7:0] PAGE_CONFIG = 8'h0f;

  // bit address = byte address with the low three bits as bit index
  localparam logic [4:0] PORT3_BIT_GROUP = 5'h16;

  // reset values
  localparam logic [7:0] RST_PORT3_OUTPUT_MODE   = 8'h00;
  localparam logic [7:0] RST_PORT3_DATA          = 8'hff;
  localparam logic [7:0] RST_PORT4_DATA          = 8'hff;
  localparam logic [7:0] RST_PORT3_CROSSBAR_SKIP = 8'h00;
  localparam logic [7:0] RST_PORT3_INPUT_MODE    = 8'hff;
  localparam logic [7:0] RST_ZERO                = 8'h00;

  // output enable is active low: released pin
  localparam logic [7:0] OE_N_RELEASED = 8'hff;

endpackage

//--- verilog/p34_pin_sync.sv
`timescale 1ns/1ps
// ****************************************************************
// two-stage synchroniser for asynchronous pin levels
// ****************************************************************
module p34_pin_sync #(
  parameter int WIDTH = 16
) (
  // clock and reset
  input  wire logic             mclk_in,
  input  wire logic             rst_n_in,
  // raw pin levels and synchronised copy
  input  wire logic [WIDTH-1:0] raw_in,
  output logic      [WIDTH-1:0] sync_out
);

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } p34_sync_state_t;

  p34_sync_state_t state_r;
  p34_sync_state_t state_nxt;

  // first stage feeds only the second stage
  always_comb begin
    state_nxt        = state_r;
    state_nxt.meta   = raw_in;
    state_nxt.stable = state_r.meta;
  end

  // reset to ones: idle pins sit high through the pull-ups
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_r <= '1;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign sync_out = state_r.stable;

endmodule

//--- verilog/p34_port.sv
`timescale 1ns/1ps
// ****************************************************************
// port 3 / port 4 pin logic and special function registers
// ****************************************************************

// Functional notes
// - data write loads pin output latch
// - data read returns sampled digital pin level
// - input-mode zero selects analog, one digital
// - analog pin loses pull-up and receiver
// - output-mode zero open-drain, one push-pull
// - output-mode ignored while pin is analog
// - skip bit hides pin from crossbar
// - port3 data in all pages, bit-addressable
// - port3 config registers only in config page
// - port4 data decodes in every page
module p34_port #(
  parameter int WIDTH = 8
) (
  // clock and reset
  input  wire logic             mclk_in,
  input  wire logic             rst_n_in,
  // special function register byte access
  input  wire logic [7:0]       sfr_addr_in,
  input  wire logic [7:0]       sfr_page_in,
  input  wire logic             sfr_wr_in,
  input  wire logic             sfr_rd_in,
  input  wire logic [7:0]       sfr_wdata_in,
  output logic      [7:0]       sfr_rdata_out,
  // special function register bit access
  input  wire logic [7:0]       bit_addr_in,
  input  wire logic             bit_wr_in,
  input  wire logic             bit_rd_in,
  input  wire logic             bit_wdata_in,
  output logic                  bit_rdata_out,
  // crossbar peripheral signals for port 3
  input  wire logic [WIDTH-1:0] xbar_en_in,
  input  wire logic [WIDTH-1:0] xbar_data_in,
  output logic      [WIDTH-1:0] port3_xbar_avail_out,
  output logic      [WIDTH-1:0] port3_pin_level_out,
  // port 3 pins
  input  wire logic [WIDTH-1:0] port3_pin_in,
  output logic      [WIDTH-1:0] port3_pin_out,
  output logic      [WIDTH-1:0] port3_pin_oe_n_out,
  output logic      [WIDTH-1:0] port3_pullup_en_out,
  output logic      [WIDTH-1:0] port3_rx_en_out,
  // port 4 pins, drive mode per pin from the port4_push_pull_in input
  input  wire logic [WIDTH-1:0] port4_push_pull_in,
  input  wire logic [WIDTH-1:0] port4_pin_in,
  output logic      [WIDTH-1:0] port4_pin_out,
  output logic      [WIDTH-1:0] port4_pin_oe_n_out
);

  typedef struct packed {
    logic [WIDTH-1:0] port3_data;
    logic [WIDTH-1:0] port4_data;
    logic [WIDTH-1:0] port3_input_mode;
    logic [WIDTH-1:0] port3_output_mode;
    logic [WIDTH-1:0] port3_crossbar_skip;
    logic [7:0]       rdata;
    logic             bit_rdata;
    logic [WIDTH-1:0] pin3_o;
    logic [WIDTH-1:0] pin3_oe_n;
    logic [WIDTH-1:0] pull3;
    logic [WIDTH-1:0] rx3;
    logic [WIDTH-1:0] level3;
    logic [WIDTH-1:0] avail3;
    logic [WIDTH-1:0] pin4_o;
    logic [WIDTH-1:0] pin4_oe_n;
  } p34_state_t;

  p34_state_t state_r;
  p34_state_t state_nxt;

  logic [2*WIDTH-1:0] pins_sync;
  logic [WIDTH-1:0]   pin3_sync;
  logic [WIDTH-1:0]   pin4_sync;

  // ****************************************************************
  // helpers
  // ****************************************************************

  // register that lives only in the configuration page
  function automatic logic cfg_hit(input logic [7:0] addr, input logic [7:0] page,
                                   input logic [7:0] target);
    cfg_hit = (addr == target) && (page == p34_pkg::PAGE_CONFIG);
  endfunction

  // pin driver: returns {level, oe_n}; open-drain only pulls low
  function automatic logic [1:0] drive(input logic value, input logic push_pull);
    if (push_pull || !value) begin
      drive = {value, 1'b0};
    end else begin
      drive = {1'b1, 1'b1};
    end
  endfunction

  // ****************************************************************
  // pin synchronisers
  // ****************************************************************

  // pins are asynchronous to mclk, so both ports pass two flops
  p34_pin_sync #(
    .WIDTH (2*WIDTH)
  ) u_sync (
    .mclk_in  (mclk_in),
    .rst_n_in (rst_n_in),
    .raw_in   ({port4_pin_in, port3_pin_in}),
    .sync_out (pins_sync)
  );

  assign pin3_sync = pins_sync[WIDTH-1:0];
  assign pin4_sync = pins_sync[2*WIDTH-1:WIDTH];

  // ****************************************************************
  // next-state logic
  // ****************************************************************

  always_comb begin
    logic [1:0]       drv;
    logic             value;
    logic             pp;
    logic [WIDTH-1:0] dig_level3;
    drv        = 2'b00;
    value      = 1'b0;
    pp         = 1'b0;
    state_nxt  = state_r;
    // analog pins read as zero since their receiver is off
    dig_level3 = pin3_sync & state_r.port3_input_mode;

    // byte writes; data registers decode in every page
    if (sfr_wr_in) begin
      if (sfr_addr_in == p34_pkg::ADDR_PORT3_DATA) begin
        state_nxt.port3_data = sfr_wdata_in[WIDTH-1:0];
      end
      if (sfr_addr_in == p34_pkg::ADDR_PORT4_DATA) begin
        state_nxt.port4_data = sfr_wdata_in[WIDTH-1:0];
      end
      if (cfg_hit(sfr_addr_in, sfr_page_in, p34_pkg::ADDR_PORT3_INPUT_MODE)) begin
        state_nxt.port3_input_mode = sfr_wdata_in[WIDTH-1:0];
      end
      if (cfg_hit(sfr_addr_in, sfr_page_in, p34_pkg::ADDR_PORT3_OUTPUT_MODE)) begin
        state_nxt.port3_output_mode = sfr_wdata_in[WIDTH-1:0];
      end
      if (cfg_hit(sfr_addr_in, sfr_page_in, p34_pkg::ADDR_PORT3_CROSSBAR_SKIP)) begin
        state_nxt.port3_crossbar_skip = sfr_wdata_in[WIDTH-1:0];
      end
    end

    // single-bit write to the port 3 latch, any page
    if (bit_wr_in && (bit_addr_in[7:3] == p34_pkg::PORT3_BIT_GROUP)) begin
      state_nxt.port3_data[bit_addr_in[2:0]] = bit_wdata_in;
    end

    // byte reads; unmapped addresses answer zero
    if (sfr_rd_in) begin
      state_nxt.rdata = p34_pkg::RST_ZERO;
      if (sfr_addr_in == p34_pkg::ADDR_PORT3_DATA) begin
        state_nxt.rdata = dig_level3;
      end else if (sfr_addr_in == p34_pkg::ADDR_PORT4_DATA) begin
        state_nxt.rdata = pin4_sync;
      end else if (cfg_hit(sfr_addr_in, sfr_page_in, p34_pkg::ADDR_PORT3_INPUT_MODE)) begin
        state_nxt.rdata = state_r.port3_input_mode;
      end else if (cfg_hit(sfr_addr_in, sfr_page_in, p34_pkg::ADDR_PORT3_OUTPUT_MODE)) begin
        state_nxt.rdata = state_r.port3_output_mode;
      end else if (cfg_hit(sfr_addr_in, sfr_page_in,
                           p34_pkg::ADDR_PORT3_CROSSBAR_SKIP)) begin
        state_nxt.rdata = state_r.port3_crossbar_skip;
      end
    end

    // single-bit read of a port 3 pin
    if (bit_rd_in) begin
      state_nxt.bit_rdata = 1'b0;
      if (bit_addr_in[7:3] == p34_pkg::PORT3_BIT_GROUP) begin
        state_nxt.bit_rdata = dig_level3[bit_addr_in[2:0]];
      end
    end

    // port 3 pin drivers from the registered configuration
    for (int i = 0; i < WIDTH; i++) begin
      // crossbar owns a digital, non-skipped pin that it enables
      if (state_r.port3_input_mode[i] && !state_r.port3_crossbar_skip[i]
          && xbar_en_in[i]) begin
        value = xbar_data_in[i];
      end else begin
        value = state_r.port3_data[i];
      end
      // analog pin: output-mode ignored, held open-drain
      pp  = state_r.port3_input_mode[i] & state_r.port3_output_mode[i];
      drv = drive(value, pp);
      state_nxt.pin3_o[i]    = drv[1];
      state_nxt.pin3_oe_n[i] = drv[0];
    end

    // analog pins lose weak pull-up and digital receiver
    state_nxt.pull3  = state_r.port3_input_mode;
    state_nxt.rx3    = state_r.port3_input_mode;
    state_nxt.level3 = dig_level3;
    state_nxt.avail3 = ~state_r.port3_crossbar_skip;

    // port 4 pin drivers from its latch
    for (int i = 0; i < WIDTH; i++) begin
      drv = drive(state_r.port4_data[i], port4_push_pull_in[i]);
      state_nxt.pin4_o[i]    = drv[1];
      state_nxt.pin4_oe_n[i] = drv[0];
    end
  end

  // ****************************************************************
  // state register
  // ****************************************************************

  // pins come out of reset released, pull-ups on, receivers on
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_r.port3_data          <= p34_pkg::RST_PORT3_DATA;
      state_r.port4_data          <= p34_pkg::RST_PORT4_DATA;
      state_r.port3_input_mode    <= p34_pkg::RST_PORT3_INPUT_MODE;
      state_r.port3_output_mode   <= p34_pkg::RST_PORT3_OUTPUT_MODE;
      state_r.port3_crossbar_skip <= p34_pkg::RST_PORT3_CROSSBAR_SKIP;
      state_r.rdata               <= p34_pkg::RST_ZERO;
      state_r.bit_rdata           <= 1'b0;
      state_r.pin3_o              <= p34_pkg::RST_PORT3_DATA;
      state_r.pin3_oe_n           <= p34_pkg::OE_N_RELEASED;
      state_r.pull3               <= p34_pkg::RST_PORT3_INPUT_MODE;
      state_r.rx3                 <= p34_pkg::RST_PORT3_INPUT_MODE;
      state_r.level3              <= p34_pkg::RST_ZERO;
      state_r.avail3              <= ~p34_pkg::RST_PORT3_CROSSBAR_SKIP;
      state_r.pin4_o              <= p34_pkg::RST_PORT4_DATA;
      state_r.pin4_oe_n           <= p34_pkg::OE_N_RELEASED;
    end else begin
      state_r <= state_nxt;
    end
  end

  // ****************************************************************
  // outputs, all straight from flops
  // ****************************************************************

  assign sfr_rdata_out        = state_r.rdata;
  assign bit_rdata_out        = state_r.bit_rdata;
  assign port3_xbar_avail_out = state_r.avail3;
  assign port3_pin_level_out  = state_r.level3;
  assign port3_pin_out        = state_r.pin3_o;
  assign port3_pin_oe_n_out   = state_r.pin3_oe_n;
  assign port3_pullup_en_out  = state_r.pull3;
  assign port3_rx_en_out      = state_r.rx3;
  assign port4_pin_out        = state_r.pin4_o;
  assign port4_pin_oe_n_out   = state_r.pin4_oe_n;

endmodule

//--- tb/p34_port_checker.sv
`timescale 1ns/1ps
// ****
// port checker
// ****
module p34_port_checker #(
  parameter int WIDTH = 8
) (
  // clock, reset, register bus
  input wire logic       mclk_in,
  input wire logic       rst_n_in,
  input wire logic [7:0] sfr_addr_in,
  input wire logic [7:0] sfr_page_in,
  input wire logic       sfr_wr_in,
  input wire logic       sfr_rd_in,
  input wire logic [7:0] sfr_wdata_in,
  input wire logic [7:0] sfr_rdata_out,
  input wire logic [7:0] bit_addr_in,
  input wire logic       bit_rd_in,
  input wire logic       bit_rdata_out,
  // pins
  input wire logic [WIDTH-1:0] port3_xbar_avail_out,
  input wire logic [WIDTH-1:0] port3_pin_out,
  input wire logic [WIDTH-1:0] port3_pin_oe_n_out,
  input wire logic [WIDTH-1:0] port3_pullup_en_out,
  input wire logic [WIDTH-1:0] port3_rx_en_out,
  input wire logic [WIDTH-1:0] port4_push_pull_in,
  input wire logic [WIDTH-1:0] port4_pin_out,
  input wire logic [WIDTH-1:0] port4_pin_oe_n_out
);
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!rst_n_in);
  // page match for the configuration registers
  wire cfg = sfr_page_in == 8'h0f;
  wire sk_wr = sfr_wr_in && sfr_addr_in == 8'hd7;
  wire p4_wr = sfr_wr_in && sfr_addr_in == 8'hb5;

  a_pullup_analog: assert property ((port3_pullup_en_out & ~port3_rx_en_out) == '0)
    else $error("pull-up on while receiver off");
  a_od_release: assert property (
    ((port3_pin_oe_n_out & ~port3_pin_out) | (port4_pin_oe_n_out & ~port4_pin_out)) == '0)
    else $error("released pin shows low drive");
  // an analog pin may only sink: its output-mode bit must not make it drive high
  a_analog_od: assert property (
    (~port3_pullup_en_out & ~port3_pin_oe_n_out & port3_pin_out) == '0)
    else $error("analog pin driven high");
  a_skip_write: assert property (sk_wr && cfg |->
    ##2 port3_xbar_avail_out == ~$past(sfr_wdata_in[WIDTH-1:0], 2))
    else $error("skip write not seen on avail");
  a_skip_page: assert property (sk_wr && !cfg |-> ##2 $stable(port3_xbar_avail_out))
    else $error("skip changed from wrong page");
  a_skip_read: assert property (sfr_rd_in && sfr_addr_in == 8'hd7 && cfg
    |-> ##1 sfr_rdata_out == ~port3_xbar_avail_out)
    else $error("skip readback differs");
  a_cfg_hidden: assert property (
    sfr_rd_in && sfr_addr_in inside {8'hae, 8'hd7, 8'hf4} && !cfg |-> ##1 sfr_rdata_out == 8'h00)
    else $error("config visible outside its page");
  a_bit_outside: assert property (
    bit_rd_in && bit_addr_in[7:3] != 5'h16 |-> ##1 !bit_rdata_out)
    else $error("bit read outside port returns one");
  a_p4_drive: assert property (
    p4_wr && &port4_push_pull_in ##1 &port4_push_pull_in && !p4_wr
    |-> ##1 port4_pin_out == $past(sfr_wdata_in[WIDTH-1:0], 2) && port4_pin_oe_n_out == '0)
    else $error("port4 push-pull drive wrong");
endmodule

//--- tb/p34_pin_model.sv
`timescale 1ns/1ps
// ****
// board pins with optional outside drivers
// ****
module p34_pin_model (
  // clock and device side
  input  wire logic       clk_in,
  input  wire logic [7:0] out_in,
  input  wire logic [7:0] oe_n_in,
  input  wire logic [7:0] pullup_in,
  // outside driver
  input  wire logic [7:0] ext_en_in,
  input  wire logic [7:0] ext_val_in,
  output logic      [7:0] pin_out
);
  logic [7:0] flt_r = 8'h55;
  // an unpulled free line wanders, so nothing may trust it
  always @(posedge clk_in) flt_r <= ~flt_r;
  // device drive wins, then outside driver, then pull-up
  assign pin_out = (~oe_n_in & out_in) | (oe_n_in & ext_en_in & ext_val_in)
    | (oe_n_in & ~ext_en_in & (pullup_in | flt_r));
endmodule

//--- tb/p34_port_tb_top.sv
`timescale 1ns/1ps
// ****
// bench
// ****
module p34_port_tb_top;
  logic mclk_in = 0, rst_n_in = 0, sfr_wr_in = 0, sfr_rd_in = 0;
  logic bit_wr_in = 0, bit_rd_in = 0, bit_wdata_in = 0, bit_rdata_out;
  logic [7:0] sfr_addr_in = '0, sfr_page_in = '0, sfr_wdata_in = '0, bit_addr_in = '0;
  logic [7:0] xbar_en_in = '0, xbar_data_in = '0, port4_push_pull_in = '0;
  logic [7:0] sfr_rdata_out, port3_xbar_avail_out, port3_pin_level_out, port3_pin_in;
  logic [7:0] port3_pin_out, port3_pin_oe_n_out, port3_pullup_en_out, port3_rx_en_out;
  logic [7:0] port4_pin_in, port4_pin_out, port4_pin_oe_n_out, pg, lv, im, om, sk, l3, l4;
  logic [7:0] e3 = '0, v3 = '0, e4 = '0, v4 = '0, eo, eoe;
  int fails = 0, n_checks = 0;

  always #2 mclk_in = ~mclk_in;
  p34_port #(.WIDTH(8)) dut (
    .mclk_in(mclk_in), .rst_n_in(rst_n_in), .sfr_addr_in(sfr_addr_in),
    .sfr_page_in(sfr_page_in), .sfr_wr_in(sfr_wr_in), .sfr_rd_in(sfr_rd_in),
    .sfr_wdata_in(sfr_wdata_in), .sfr_rdata_out(sfr_rdata_out), .bit_addr_in(bit_addr_in),
    .bit_wr_in(bit_wr_in), .bit_rd_in(bit_rd_in), .bit_wdata_in(bit_wdata_in),
    .bit_rdata_out(bit_rdata_out), .xbar_en_in(xbar_en_in), .xbar_data_in(xbar_data_in),
    .port3_xbar_avail_out(port3_xbar_avail_out), .port3_pin_level_out(port3_pin_level_out),
    .port3_pin_in(port3_pin_in), .port3_pin_out(port3_pin_out),
    .port3_pin_oe_n_out(port3_pin_oe_n_out), .port3_pullup_en_out(port3_pullup_en_out),
    .port3_rx_en_out(port3_rx_en_out), .port4_push_pull_in(port4_push_pull_in),
    .port4_pin_in(port4_pin_in), .port4_pin_out(port4_pin_out),
    .port4_pin_oe_n_out(port4_pin_oe_n_out));
  p34_pin_model m3 (.clk_in(mclk_in), .out_in(port3_pin_out), .oe_n_in(port3_pin_oe_n_out),
    .pullup_in(port3_pullup_en_out), .ext_en_in(e3), .ext_val_in(v3), .pin_out(port3_pin_in));
  p34_pin_model m4 (.clk_in(mclk_in), .out_in(port4_pin_out), .oe_n_in(port4_pin_oe_n_out),
    .pullup_in(8'hff), .ext_en_in(e4), .ext_val_in(v4), .pin_out(port4_pin_in));

  // ****
  // helpers
  // ****
  task automatic chk(string nm, logic [7:0] got, logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // one-cycle byte write or read; read data lands one edge later
  task automatic acc(logic w, logic [7:0] a, logic [7:0] p, logic [7:0] d);
    @(negedge mclk_in);
    {sfr_wr_in, sfr_rd_in, sfr_addr_in, sfr_page_in, sfr_wdata_in} = {w, ~w, a, p, d};
    @(negedge mclk_in);
    {sfr_wr_in, sfr_rd_in} = 2'b00;
  endtask
  task automatic rd(string nm, logic [7:0] a, logic [7:0] p, logic [7:0] exp);
    acc(1'b0, a, p, 8'h00);
    chk(nm, sfr_rdata_out, exp);
  endtask
  task automatic bt(logic w, logic [7:0] a, logic v);
    @(negedge mclk_in);
    {bit_wr_in, bit_rd_in, bit_addr_in, bit_wdata_in} = {w, ~w, a, v};
    @(negedge mclk_in);
    {bit_wr_in, bit_rd_in} = 2'b00;
  endtask
  // expected {level, release}: crossbar wins on enabled digital unskipped pins
  function automatic logic [15:0] drv(logic [7:0] i, o, s, e, x, l);
    logic [7:0] v;
    v = (i & ~s & e & x) | (~(i & ~s & e) & l);
    return {v, ~(i & o) & v};
  endfunction
  function automatic logic [7:0] lvl(logic [7:0] oe, o, en, val, pu);
    return (~oe & o) | (oe & en & val) | (oe & ~en & pu);
  endfunction
  task automatic finish_test;
    $display("checks %0d fails %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // ****
  // sequence
  // ****
  initial begin
    void'($urandom(89691));
    repeat (20) @(negedge mclk_in);
    rst_n_in = 1;
    chk("oe3", port3_pin_oe_n_out, 8'hff);
    chk("av3", port3_xbar_avail_out, 8'hff);
    rd("im", 8'hf4, 8'h0f, 8'hff);
    rd("om", 8'hae, 8'h0f, 8'h00);
    rd("none", 8'h00, 8'h0f, 8'h00);
    for (int i = 0; i < 24; i++) begin
      {im, om, sk, l3} = $urandom;
      {xbar_en_in, xbar_data_in, port4_push_pull_in, l4} = $urandom;
      {e3, v3, e4, pg} = $urandom;
      // first pass: analog pins with push-pull set, port4 all push-pull
      if (i == 0) {im, om, port4_push_pull_in} = {8'h0f, 8'hff, 8'hff};
      if (i[0]) om = om & im;
      {eo, eoe} = drv(im, om, sk, xbar_en_in, xbar_data_in, l3);
      // outside drivers only on released pins; analog ones always held
      e3 = (e3 | ~im) & eoe;
      e4 = e4 & ~port4_push_pull_in & l4;
      v4 = ~pg;
      acc(1'b1, 8'hd7, pg | 8'h10, ~sk);
      acc(1'b1, 8'hf4, 8'h0f, im);
      acc(1'b1, 8'hae, 8'h0f, om);
      acc(1'b1, 8'hd7, 8'h0f, sk);
      acc(1'b1, 8'hb5, pg, l4);
      if (i[0]) acc(1'b1, 8'hb0, pg, l3);
      else for (int b = 0; b < 8; b++) bt(1'b1, {5'h16, 3'(b)}, l3[b]);
      repeat (6) @(negedge mclk_in);
      chk("out3", port3_pin_out, eo);
      chk("oe3", port3_pin_oe_n_out, eoe);
      chk("pu3", port3_pullup_en_out, im);
      chk("rx3", port3_rx_en_out, im);
      chk("av3", port3_xbar_avail_out, ~sk);
      chk("out4", port4_pin_out, l4);
      chk("oe4", port4_pin_oe_n_out, ~port4_push_pull_in & l4);
      lv = lvl(eoe, eo, e3, v3, im) & im;
      chk("lvl3", port3_pin_level_out, lv);
      rd("p3", 8'hb0, pg, lv);
      rd("p4", 8'hb5, pg, lvl(~port4_push_pull_in & l4, l4, e4, v4, 8'hff));
      rd("sk", 8'hd7, 8'h0f, sk);
      rd("hid", 8'hf4, pg | 8'h10, 8'h00);
      bt(1'b0, {5'h16, i[2:0]}, 1'b0);
      chk("bit", {7'h0, bit_rdata_out}, {7'h0, lv[i[2:0]]});
    end
    bt(1'b0, 8'hb8, 1'b0);
    chk("bitx", {7'h0, bit_rdata_out}, 8'h00);
    finish_test();
  end
endmodule

bind p34_port p34_port_checker #(.WIDTH(WIDTH)) chk_i (
  .mclk_in(mclk_in), .rst_n_in(rst_n_in), .sfr_addr_in(sfr_addr_in),
  .sfr_page_in(sfr_page_in), .sfr_wr_in(sfr_wr_in), .sfr_rd_in(sfr_rd_in),
  .sfr_wdata_in(sfr_wdata_in), .sfr_rdata_out(sfr_rdata_out), .bit_addr_in(bit_addr_in),
  .bit_rd_in(bit_rd_in), .bit_rdata_out(bit_rdata_out),
  .port3_xbar_avail_out(port3_xbar_avail_out), .port3_pin_out(port3_pin_out),
  .port3_pin_oe_n_out(port3_pin_oe_n_out), .port3_pullup_en_out(port3_pullup_en_out),
  .port3_rx_en_out(port3_rx_en_out), .port4_push_pull_in(port4_push_pull_in),
  .port4_pin_out(port4_pin_out), .port4_pin_oe_n_out(port4_pin_oe_n_out));
